// *** core/op_tracker.sv ***
`timescale 1ns/100ps
`include "tsb_consts.svh"

// Counts outstanding operations in the current epoch and in all sealed epochs
module op_tracker
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic inc,
  input wire logic dec_cur,
  input wire logic dec_old,
  input wire logic seal,
  output logic [`TSB_CNT_W-1:0] cur_cnt,
  output logic [`TSB_CNT_W-1:0] old_cnt
);

  logic [`TSB_CNT_W-1:0] inc_w;
  logic [`TSB_CNT_W-1:0] dec_cur_w;
  logic [`TSB_CNT_W-1:0] dec_old_w;
  logic [`TSB_CNT_W-1:0] cur_nxt;

  assign inc_w = {{(`TSB_CNT_W-1){1'b0}}, inc};
  assign dec_cur_w = {{(`TSB_CNT_W-1){1'b0}}, dec_cur};
  assign dec_old_w = {{(`TSB_CNT_W-1){1'b0}}, dec_old};
  assign cur_nxt = cur_cnt + inc_w - dec_cur_w;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cur_cnt <= '0;
      old_cnt <= '0;
    end
    else if (seal)
    begin
      // Work issued in the sealing cycle belongs to the sealed set
      old_cnt <= old_cnt + cur_nxt - dec_old_w;
      cur_cnt <= '0;
    end
    else
    begin
      cur_cnt <= cur_nxt;
      old_cnt <= old_cnt - dec_old_w;
    end
  end

endmodule

// *** core/trace_sync_barrier_control.sv ***
`timescale 1ns/100ps
`include "tsb_consts.svh"

module trace_sync_barrier_control
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`TSB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic instr_valid,
  input wire logic instr_spec,
  input wire logic [1:0] instr_el,
  input wire logic instr_in_host,
  input wire logic instr_debug,
  input wire logic instr_is_cse,
  input wire logic trace_sync_barrier_instr,
  input wire logic irq_pending,
  input wire logic auto_op_start,
  input wire logic op_done_valid,
  input wire logic op_done_epoch,
  input wire logic op_done_spec,
  input wire logic op_done_auto,
  input wire logic op_mem_complete,
  input wire logic flush_start,
  input wire logic flush_complete,
  input wire logic flush_wr_done,
  input wire logic unit_paused,
  output logic op_req_valid,
  output logic op_req_epoch,
  output logic op_req_spec,
  output logic op_req_ctx_rd,
  output logic op_req_ts_rd,
  output logic [1:0] op_req_class,
  output logic unit_quiesce,
  output logic sync_event,
  output logic tsb_busy,
  output logic tsb_done,
  output logic tsb_abandon,
  output logic sysreg_wr_stall,
  output logic trace_mem_synced,
  output logic trace_wr_observable
);

  logic [7:0] ctrl_r;
  logic prohib_r;
  logic cse_seen_r;
  logic epoch_r;
  logic flush_active_r;
  logic flush_wr_pend_r;
  logic overdue_r;
  logic [`TSB_LAT_W-1:0] lat_r;
  tsb_pkg::barrier_state_e state_r;
  tsb_pkg::barrier_state_e state_nxt;

  logic wb_req;
  logic wb_wr;
  logic allowed;
  logic gen_op;
  logic tsb_issue;
  logic in_barrier;
  logic drain_ok;
  logic flush_busy;
  logic done_match;
  logic res_to_cur;
  logic spec_to_cur;
  logic [`TSB_CNT_W-1:0] res_cur;
  logic [`TSB_CNT_W-1:0] res_old;
  logic [`TSB_CNT_W-1:0] spec_cur;
  logic [`TSB_CNT_W-1:0] spec_old;
  logic [`TSB_CNT_W-1:0] auto_cnt;
  logic [`TSB_CNT_W-1:0] cmpl_cnt;
  logic [31:0] rd_data;

  // Bus slave: one wait state, ack drops the cycle after it was given
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  // Filter controls, enable and lock are sampled as reads made by the instruction
  always_comb
  begin
    allowed = 1'b0;
    case (instr_el)
      `TSB_EL_USER:
      begin
        allowed = instr_in_host ? ctrl_r[`TSB_BIT_HYP_USER_ALLOW]
                                : ctrl_r[`TSB_BIT_USER_ALLOW];
      end
      `TSB_EL_KERNEL:
      begin
        allowed = ctrl_r[`TSB_BIT_KERNEL_ALLOW];
      end
      `TSB_EL_HYP:
      begin
        allowed = ctrl_r[`TSB_BIT_HYP_ALLOW];
      end
      default:
      begin
        allowed = 1'b0;
      end
    endcase
  end

  assign gen_op = instr_valid && allowed && ctrl_r[`TSB_BIT_UNIT_EN]
                  && !ctrl_r[`TSB_BIT_OS_LOCK] && !unit_quiesce;
  assign tsb_issue = instr_valid && trace_sync_barrier_instr && state_r == tsb_pkg::ST_IDLE;
  assign in_barrier = !instr_debug && prohib_r && cse_seen_r;
  assign done_match = op_done_epoch == epoch_r;
  // Two-epoch tags wrap: with nothing current, a matching tag retires an old op
  assign res_to_cur = done_match && res_cur != '0;
  assign spec_to_cur = done_match && spec_cur != '0;
  assign flush_busy = flush_active_r || flush_wr_pend_r;

  // Register file
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_r <= `TSB_CTRL_RESET;
    end
    else if (wb_wr && wb_adr_i == `TSB_OFS_CTRL && wb_sel_i[0])
    begin
      ctrl_r <= wb_dat_i[7:0];
    end
  end

  always_comb
  begin
    rd_data = 32'h0;
    case (wb_adr_i)
      `TSB_OFS_CTRL:
      begin
        rd_data = {24'h0, ctrl_r};
      end
      `TSB_OFS_STATUS:
      begin
        rd_data = {24'h0, overdue_r, flush_wr_pend_r, flush_active_r, cse_seen_r,
                   prohib_r, unit_quiesce, state_r};
      end
      `TSB_OFS_COUNTS:
      begin
        rd_data = {8'h0, cmpl_cnt, auto_cnt, spec_old, res_old};
      end
      default:
      begin
        rd_data = 32'h0;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : 32'h0;
    end
  end

  // Region and epoch tracking; a context synchronization event seals the outstanding set
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prohib_r <= 1'b1;
      cse_seen_r <= 1'b0;
      epoch_r <= 1'b0;
    end
    else if (instr_valid && instr_is_cse)
    begin
      prohib_r <= !allowed;
      cse_seen_r <= 1'b1;
      epoch_r <= !epoch_r;
    end
  end

  // Trace operation request, issued apart from the pipeline
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      op_req_valid <= 1'b0;
      op_req_epoch <= 1'b0;
      op_req_spec <= 1'b0;
      op_req_ctx_rd <= 1'b0;
      op_req_ts_rd <= 1'b0;
      op_req_class <= tsb_pkg::ACC_OTHER;
    end
    else
    begin
      op_req_valid <= gen_op;
      op_req_epoch <= epoch_r;
      op_req_spec <= instr_spec;
      op_req_ctx_rd <= gen_op && ctrl_r[`TSB_BIT_CTX_EN];
      op_req_ts_rd <= gen_op && ctrl_r[`TSB_BIT_TS_EN];
      op_req_class <= gen_op ? tsb_pkg::ACC_BY_OP : tsb_pkg::ACC_BY_INSTR;
    end
  end

  // An op is counted until the unit reports all its register accesses performed
  op_tracker u_res
  (
    .mclk(mclk),
    .rst(rst),
    .inc(gen_op && !instr_spec),
    .dec_cur(op_done_valid && !op_done_auto && !op_done_spec && res_to_cur),
    .dec_old(op_done_valid && !op_done_auto && !op_done_spec && !res_to_cur),
    .seal(instr_valid && instr_is_cse),
    .cur_cnt(res_cur),
    .old_cnt(res_old)
  );

  op_tracker u_spec
  (
    .mclk(mclk),
    .rst(rst),
    .inc(gen_op && instr_spec),
    .dec_cur(op_done_valid && !op_done_auto && op_done_spec && spec_to_cur),
    .dec_old(op_done_valid && !op_done_auto && op_done_spec && !spec_to_cur),
    .seal(instr_valid && instr_is_cse),
    .cur_cnt(spec_cur),
    .old_cnt(spec_old)
  );

  op_tracker u_auto
  (
    .mclk(mclk),
    .rst(rst),
    .inc(auto_op_start),
    .dec_cur(op_done_valid && op_done_auto),
    .dec_old(1'b0),
    .seal(1'b0),
    .cur_cnt(auto_cnt),
    .old_cnt()
  );

  // Finished but not yet complete: memory and abort writes outstanding
  op_tracker u_cmpl
  (
    .mclk(mclk),
    .rst(rst),
    .inc(op_done_valid),
    .dec_cur(op_mem_complete),
    .dec_old(1'b0),
    .seal(1'b0),
    .cur_cnt(cmpl_cnt),
    .old_cnt()
  );

  // Flush tracking; a new flush wins over a clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      flush_active_r <= 1'b0;
      flush_wr_pend_r <= 1'b0;
    end
    else
    begin
      flush_active_r <= flush_start || (flush_active_r && !flush_complete);
      flush_wr_pend_r <= (flush_active_r && flush_complete)
                         || (flush_wr_pend_r && !flush_wr_done);
    end
  end

  // Overdue watch on trace ops that never come back
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lat_r <= '0;
      overdue_r <= 1'b0;
    end
    else
    begin
      if (op_done_valid || (res_cur == '0 && res_old == '0 && spec_cur == '0
          && spec_old == '0 && auto_cnt == '0))
      begin
        lat_r <= '0;
      end
      else if (lat_r != `TSB_LATENCY_MAX)
      begin
        lat_r <= lat_r + 1'b1;
      end
      if (lat_r == `TSB_LATENCY_MAX)
      begin
        overdue_r <= 1'b1;
      end
      else if (wb_wr && wb_adr_i == `TSB_OFS_STATUS && wb_sel_i[0] && wb_dat_i[7])
      begin
        overdue_r <= 1'b0;
      end
    end
  end

  // Drain waits on accepted ops, the unit pausing and any flush, never on the buffer emptying
  assign drain_ok = res_old == '0 && spec_old == '0
                    && auto_cnt == '0 && unit_paused
                    && !flush_busy;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      tsb_pkg::ST_IDLE:
      begin
        if (tsb_issue)
        begin
          state_nxt = in_barrier ? tsb_pkg::ST_DRAIN : tsb_pkg::ST_DONE;
        end
      end
      tsb_pkg::ST_DRAIN:
      begin
        if (irq_pending && !instr_debug)
        begin
          state_nxt = tsb_pkg::ST_IDLE;
        end
        else if (flush_busy)
        begin
          state_nxt = tsb_pkg::ST_FLUSH;
        end
        else if (drain_ok)
        begin
          state_nxt = tsb_pkg::ST_DONE;
        end
      end
      tsb_pkg::ST_FLUSH:
      begin
        if (irq_pending && !instr_debug)
        begin
          state_nxt = tsb_pkg::ST_IDLE;
        end
        else if (!flush_busy)
        begin
          state_nxt = tsb_pkg::ST_DRAIN;
        end
      end
      tsb_pkg::ST_DONE:
      begin
        state_nxt = tsb_pkg::ST_IDLE;
      end
      default:
      begin
        state_nxt = tsb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= tsb_pkg::ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Pipeline facing handshake
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync_event <= 1'b0;
      tsb_busy <= 1'b0;
      tsb_done <= 1'b0;
      tsb_abandon <= 1'b0;
      sysreg_wr_stall <= 1'b0;
    end
    else
    begin
      sync_event <= tsb_issue;
      tsb_busy <= state_nxt == tsb_pkg::ST_DRAIN || state_nxt == tsb_pkg::ST_FLUSH;
      tsb_done <= state_nxt == tsb_pkg::ST_DONE;
      tsb_abandon <= state_r != tsb_pkg::ST_IDLE && state_r != tsb_pkg::ST_DONE
                     && state_nxt == tsb_pkg::ST_IDLE;
      // Later direct writes wait until earlier trace accesses have finished
      sysreg_wr_stall <= tsb_issue
                         || (state_nxt != tsb_pkg::ST_IDLE
                             && state_nxt != tsb_pkg::ST_DONE);
    end
  end

  // Quiet state holds for as long as execution stays in the prohibited region
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      unit_quiesce <= 1'b0;
    end
    else if (tsb_issue && in_barrier)
    begin
      unit_quiesce <= 1'b1;
    end
    else if (instr_valid && instr_is_cse && allowed)
    begin
      unit_quiesce <= 1'b0;
    end
  end

  // Visibility of trace effects is only claimed after a finished barrier
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      trace_mem_synced <= 1'b0;
      trace_wr_observable <= 1'b0;
    end
    else
    begin
      if (gen_op || auto_op_start)
      begin
        trace_wr_observable <= 1'b0;
      end
      else if (state_r == tsb_pkg::ST_DONE)
      begin
        trace_wr_observable <= 1'b1;
      end
      if (gen_op || auto_op_start || op_done_valid)
      begin
        trace_mem_synced <= 1'b0;
      end
      else if (state_r == tsb_pkg::ST_DONE && cmpl_cnt == '0)
      begin
        trace_mem_synced <= 1'b1;
      end
    end
  end

endmodule

// *** core/tsb_consts.svh ***
// Contract
// - Trace operations run apart from instructions, accessing registers as an outside agent.
// - Trace filter allow bits read for tracing decisions count as that instruction's reads.
// - Each trace register access is classed: by instruction, by trace op, or other.
// - Unit enable and OS lock bits are read by the instruction deciding tracing.
// - Trace ops read context IDs and counter offsets when those features are on.
// - Without synchronization, trace data is produced and handled within finite time.
// - Memory write of accepted trace data is not assumed complete before synchronization.
// - Register writes by trace ops are observable only after synchronization.
// - Executing the barrier instruction raises a trace synchronization event.
// - A trace op is not finished until all its register accesses are performed.
// - A flush-triggering op waits for flush, accepted ops and flush writes.
// - Finishing counts translation, secure-state and management writes, not abort writes.
// - A trace op completes once finished, memory done and abort writes performed.
// - Prohibited-region barrier waits for ops of instructions before the sync event.
// - It also waits for speculative ops not ordered after the sync event.
// - It also waits for all autonomously generated trace ops.
// - Before finishing, the unit goes quiet and stays so in the prohibited region.
// - A flush started before barrier finish must complete with its writes first.
// - Direct register writes after the barrier are ordered after earlier trace accesses.
// - The barrier never stalls forever nor waits for the buffer to drain.
// - An unfinished barrier may be abandoned for an interrupt and re-executed.
// - Without sync event or barrier, the barrier is unordered; software adds barriers.
`ifndef TSB_CONSTS_SVH
`define TSB_CONSTS_SVH

`define TSB_ADR_W 8
`define TSB_CNT_W 6
`define TSB_OFS_CTRL 8'h00
`define TSB_OFS_STATUS 8'h04
`define TSB_OFS_COUNTS 8'h08

`define TSB_CTRL_RESET 8'h00
`define TSB_BIT_UNIT_EN 0
`define TSB_BIT_OS_LOCK 1
`define TSB_BIT_KERNEL_ALLOW 2
`define TSB_BIT_USER_ALLOW 3
`define TSB_BIT_HYP_ALLOW 4
`define TSB_BIT_HYP_USER_ALLOW 5
`define TSB_BIT_CTX_EN 6
`define TSB_BIT_TS_EN 7

`define TSB_EL_USER 2'h0
`define TSB_EL_KERNEL 2'h1
`define TSB_EL_HYP 2'h2

`define TSB_LATENCY_MAX 11'h400
`define TSB_LAT_W 11

`endif

// *** core/tsb_pkg.sv ***
package tsb_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DRAIN = 2'h1,
    ST_FLUSH = 2'h3,
    ST_DONE = 2'h2
  } barrier_state_e;

  typedef enum logic [1:0] {
    ACC_BY_INSTR = 2'h0,
    ACC_BY_OP = 2'h1,
    ACC_OTHER = 2'h2
  } access_class_e;

endpackage

// *** verification/trace_sync_barrier_control_tb_top.sv ***
`timescale 1ns/100ps
`include "tsb_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end

module trace_sync_barrier_control_tb_top;
  logic mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instr_valid, instr_spec;
  logic [`TSB_ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [1:0] instr_el, op_req_class;
  logic instr_in_host, instr_debug, instr_is_cse, trace_sync_barrier_instr, irq_pending;
  logic auto_op_start, op_done_valid, op_done_epoch, op_done_spec, op_done_auto;
  logic op_mem_complete, flush_start, flush_complete, flush_wr_done, unit_paused;
  logic op_req_valid, op_req_epoch, op_req_spec, op_req_ctx_rd, op_req_ts_rd, unit_quiesce;
  logic sync_event, tsb_busy, tsb_done, tsb_abandon, sysreg_wr_stall, trace_mem_synced;
  logic trace_wr_observable, auto_go, flush_go, model_busy;
  logic [7:0] lat;
  logic [7:0] ctrl_tbl [3] = '{8'h3D, 8'hC7, 8'hC5};
  logic [3:0] exp_tbl [3] = '{4'h7, 4'h0, 4'h2};
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  trace_sync_barrier_control u_dut
  (
    .mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .instr_valid, .instr_spec, .instr_el, .instr_in_host, .instr_debug,
    .instr_is_cse, .trace_sync_barrier_instr, .irq_pending, .auto_op_start, .op_done_valid,
    .op_done_epoch, .op_done_spec, .op_done_auto, .op_mem_complete, .flush_start,
    .flush_complete, .flush_wr_done, .unit_paused, .op_req_valid, .op_req_epoch, .op_req_spec,
    .op_req_ctx_rd, .op_req_ts_rd, .op_req_class, .unit_quiesce, .sync_event, .tsb_busy,
    .tsb_done, .tsb_abandon, .sysreg_wr_stall, .trace_mem_synced, .trace_wr_observable
  );
  trace_unit_model u_model
  (
    .mclk, .rst, .op_req_valid, .op_req_epoch, .op_req_spec, .unit_quiesce, .auto_go,
    .flush_go, .lat, .auto_op_start, .op_done_valid, .op_done_epoch, .op_done_spec,
    .op_done_auto, .op_mem_complete, .flush_start, .flush_complete, .flush_wr_done,
    .unit_paused, .model_busy
  );

  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [`TSB_ADR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do
      @(posedge mclk);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // One-cycle instruction; returns just after the edge that samples it
  task automatic instr(input logic [1:0] el, input logic spec, context_sync_event, bar);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_el <= el;
    instr_spec <= spec;
    instr_is_cse <= context_sync_event;
    trace_sync_barrier_instr <= bar;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial
  begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, instr_valid, instr_spec, instr_in_host} = '0;
    {instr_debug, instr_is_cse, trace_sync_barrier_instr, irq_pending, auto_go, flush_go} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, instr_el} = '0;
    lat = 8'h02;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, `TSB_OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, `TSB_OFS_STATUS, 32'h0);
    `CHK(rd, 32'h8)
    bus(1'b1, 8'h0C, 32'hFF);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, `TSB_OFS_CTRL, {24'h0, ctrl_tbl[i]});
      bus(1'b0, `TSB_OFS_CTRL, 32'h0);
      `CHK(rd, {24'h0, ctrl_tbl[i]})
      for (int e = 0; e < 4; e++)
      begin
        instr(2'(e), 1'b0, 1'b0, 1'b0);
        `CHK(op_req_valid, exp_tbl[i][e])
        `CHK({op_req_spec, op_req_epoch, op_req_class}, {3'h0, exp_tbl[i][e]})
        if (exp_tbl[i][e])
          `CHK({op_req_ctx_rd, op_req_ts_rd}, {ctrl_tbl[i][6], ctrl_tbl[i][7]})
      end
    end
    instr(2'h1, 1'b0, 1'b1, 1'b0);
    instr(2'h1, 1'b0, 1'b0, 1'b1);
    `CHK(sync_event, 1'b1)
    `CHK({tsb_done, tsb_busy}, 2'b10)
    @(posedge mclk);
    #1;
    `CHK({tsb_done, sysreg_wr_stall}, 2'b00)
    lat <= 8'h28;
    for (int v = 0; v < 2; v++)
    begin
      instr(2'h1, 1'b0, 1'b1, 1'b0);
      if (v == 0)
      begin
        instr(2'h1, 1'b1, 1'b0, 1'b0);
        `CHK({op_req_valid, op_req_spec}, 2'b11)
      end
      else
      begin
        @(posedge mclk);
        auto_go <= 1'b1;
        flush_go <= 1'b1;
        @(posedge mclk);
        auto_go <= 1'b0;
        flush_go <= 1'b0;
      end
      instr(2'h0, 1'b0, 1'b1, 1'b0);
      instr(2'h0, 1'b0, 1'b0, 1'b1);
      `CHK({sync_event, tsb_busy, unit_quiesce, sysreg_wr_stall}, 4'hF)
      `CHK({trace_wr_observable, trace_mem_synced}, 2'b00)
      bus(1'b0, `TSB_OFS_COUNTS, 32'h0);
      `CHK(rd, (v == 0) ? 32'h42 : 32'h1000)
      while (tsb_done !== 1'b1)
        @(posedge mclk);
      #1;
      `CHK({model_busy, unit_paused}, 2'b01)
      `CHK(trace_wr_observable, 1'b1)
      `CHK(trace_mem_synced, 1'b1)
      instr(2'h1, 1'b0, 1'b0, 1'b0);
      `CHK(op_req_valid, 1'b0)
    end
    lat <= 8'hC8;
    instr(2'h1, 1'b0, 1'b1, 1'b0);
    instr(2'h0, 1'b0, 1'b1, 1'b0);
    instr(2'h0, 1'b0, 1'b0, 1'b1);
    repeat (3) @(posedge mclk);
    irq_pending <= 1'b1;
    while (tsb_abandon !== 1'b1)
      @(posedge mclk);
    irq_pending <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK({tsb_busy, tsb_done, tsb_abandon, sysreg_wr_stall}, 4'h0)
    bus(1'b0, `TSB_OFS_STATUS, 32'h0);
    `CHK(rd, 32'h1C)
    instr(2'h0, 1'b0, 1'b0, 1'b1);
    `CHK(sync_event, 1'b1)
    while (tsb_done !== 1'b1)
      @(posedge mclk);
    #1;
    `CHK(model_busy, 1'b0)
    bus(1'b0, `TSB_OFS_COUNTS, 32'h0);
    `CHK(rd, 32'h0)
    report_and_stop();
  end
endmodule

bind trace_sync_barrier_control tsb_props u_props
(
  .mclk, .rst, .instr_valid, .trace_sync_barrier_instr, .irq_pending, .unit_paused,
  .op_req_valid, .op_req_class, .unit_quiesce, .sync_event, .tsb_busy, .tsb_done,
  .tsb_abandon, .sysreg_wr_stall
);

// *** verification/trace_unit_model.sv ***
`timescale 1ns/100ps
module trace_unit_model
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic op_req_valid,
  input wire logic op_req_epoch,
  input wire logic op_req_spec,
  input wire logic unit_quiesce,
  input wire logic auto_go,
  input wire logic flush_go,
  input wire logic [7:0] lat,
  output logic auto_op_start,
  output logic op_done_valid,
  output logic op_done_epoch,
  output logic op_done_spec,
  output logic op_done_auto,
  output logic op_mem_complete,
  output logic flush_start,
  output logic flush_complete,
  output logic flush_wr_done,
  output logic unit_paused,
  output logic model_busy
);
  logic [2:0] q[$];
  logic [2:0] h;
  logic [7:0] cnt_r, pz_r;
  logic [3:0] fl_r;
  initial
  begin
    {auto_op_start, op_done_valid, op_done_epoch, op_done_spec, op_done_auto} = '0;
    {op_mem_complete, cnt_r, pz_r, fl_r} = '0;
  end
  assign model_busy = (q.size() != 0) || (fl_r != 4'h0);
  assign flush_start = fl_r == 4'h1;
  assign flush_complete = fl_r == 4'h5;
  assign flush_wr_done = fl_r == 4'h7;
  assign unit_paused = unit_quiesce && (pz_r >= lat);
  always @(posedge mclk)
  begin
    op_done_valid <= 1'b0;
    op_mem_complete <= op_done_valid;
    auto_op_start <= auto_go && !unit_quiesce && !rst;
    {op_done_epoch, op_done_spec, op_done_auto} <= ~{op_done_epoch, op_done_spec, op_done_auto};
    pz_r <= !unit_quiesce ? 8'h00 : ((pz_r == 8'hFF) ? pz_r : pz_r + 8'h01);
    if (rst)
    begin
      q.delete();
      cnt_r <= 8'h00;
      fl_r <= 4'h0;
    end
    else
    begin
      if (op_req_valid)
        q.push_back({op_req_epoch, op_req_spec, 1'b0});
      if (auto_go && !unit_quiesce)
        q.push_back(3'b001);
      fl_r <= flush_go ? 4'h1 : ((fl_r == 4'h7 || fl_r == 4'h0) ? 4'h0 : fl_r + 4'h1);
      if (q.size() != 0)
        cnt_r <= cnt_r + 8'h01;
      if (q.size() != 0 && cnt_r >= lat)
      begin
        h = q.pop_front();
        op_done_valid <= 1'b1;
        {op_done_epoch, op_done_spec, op_done_auto} <= h;
        cnt_r <= 8'h00;
      end
    end
  end
endmodule

// *** verification/tsb_props.sv ***
`timescale 1ns/100ps
module tsb_props
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic trace_sync_barrier_instr,
  input wire logic irq_pending,
  input wire logic unit_paused,
  input wire logic op_req_valid,
  input wire logic [1:0] op_req_class,
  input wire logic unit_quiesce,
  input wire logic sync_event,
  input wire logic tsb_busy,
  input wire logic tsb_done,
  input wire logic tsb_abandon,
  input wire logic sysreg_wr_stall
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_sync_cause;
    sync_event |-> $past(instr_valid && trace_sync_barrier_instr);
  endproperty
  a_sync_cause: assert property (p_sync_cause)
    else $error("sync event without barrier");
  property p_sync_once;
    sync_event |=> !sync_event;
  endproperty
  a_sync_once: assert property (p_sync_once)
    else $error("sync event longer than one cycle");
  property p_req_cause;
    op_req_valid |-> $past(instr_valid);
  endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("op request without instruction");
  property p_req_class;
    op_req_valid |-> op_req_class == 2'h1;
  endproperty
  a_req_class: assert property (p_req_class)
    else $error("op request with wrong access class");
  property p_quiet;
    unit_quiesce |=> !op_req_valid;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("op request while quiesced");
  property p_wait_paused;
    tsb_busy && !unit_paused |=> !tsb_done;
  endproperty
  a_wait_paused: assert property (p_wait_paused)
    else $error("barrier finished before unit paused");
  property p_stall;
    tsb_busy |-> sysreg_wr_stall;
  endproperty
  a_stall: assert property (p_stall)
    else $error("direct writes not held while barrier waits");
  property p_abandon;
    tsb_abandon |-> $past(irq_pending) && $past(tsb_busy);
  endproperty
  a_abandon: assert property (p_abandon)
    else $error("abandon without interrupt on waiting barrier");
  property p_bound;
    $rose(tsb_busy) |-> ##[1:900] !tsb_busy;
  endproperty
  a_bound: assert property (p_bound)
    else $error("barrier wait not bounded");
endmodule
